// >>> pkg/port_mux_pkg.sv
// Shared types and constants for the port function multiplexer.
// Assumes one clock domain and configuration bits held by the caller.
package port_mux_pkg;

  // ************************************************************
  // Geometry and port indices
  // ************************************************************
  localparam int NUM_PORTS = 7;          // Seven general ports
  localparam int PORT_W    = 8;          // Pins in a port
  localparam int ADDR_W    = 16;         // Host address/data port width
  localparam int PORT_ONE   = 0;         // Macrocell group one port
  localparam int PORT_TWO   = 1;         // Macrocell group two port
  localparam int PORT_THREE = 2;         // Chip-select capable port
  localparam int PORT_FOUR  = 3;         // Strobe, clock and select port
  localparam int PORT_FIVE  = 4;         // Programming and battery port
  localparam int PORT_SIX   = 5;         // Extended address and data port
  localparam int PORT_SEVEN = 6;         // Address output port

  // ************************************************************
  // Special pin positions
  // ************************************************************
  localparam int PIN_STROBE  = 0;        // Address strobe on port four
  localparam int PIN_LCLK    = 1;        // Logic clock on port four
  localparam int PIN_CSEL    = 2;        // Chip-select input on port four
  localparam int PIN_TMS     = 0;        // Test mode select on port five
  localparam int PIN_TCK     = 1;        // Test clock on port five
  localparam int PIN_TDI     = 2;        // Test data in on port five
  localparam int PIN_TDO     = 3;        // Test data out on port five
  localparam int PIN_STAT    = 4;        // Programming status on port five
  localparam int PIN_PERR    = 5;        // Programming error on port five
  localparam int PIN_BATT    = 7;        // Battery indicator on port five
  localparam int XA_ADDR_W   = 4;        // Low address inputs in extended mode
  localparam int HI_BYTE     = 8;        // First bit of high address byte

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] BYTE_ZERO = 8'h00;   // Inputs, no drive
  localparam logic [15:0] ADDR_ZERO = 16'h0000; // Cleared address latch

  // ************************************************************
  // Types
  // ************************************************************
  // Function of a pin on the first three ports
  typedef enum logic [1:0] {
    SEL_MCU_IO = 2'b00,                  // Plain controller I/O
    SEL_ALT    = 2'b01,                  // Macrocell or chip-select output
    SEL_PLD_IN = 2'b10                   // Input to the logic array
  } pin_sel_type;

  // How a logic array input is taken
  typedef enum logic [1:0] {
    PLD_TRANSPARENT = 2'b00,             // Follows the pin
    PLD_LATCHED     = 2'b01,             // Caught on address strobe
    PLD_REGISTERED  = 2'b10              // Caught on logic clock tick
  } pld_mode_type;

  // Per-port controller registers
  typedef struct packed {
    logic [7:0] dir;                     // 1 = output
    logic [7:0] dout;                    // Data to drive
    logic [7:0] ctrl;                    // 1 = latched address out
  } port_cfg_type;

  // Special function enables
  typedef struct packed {
    logic strobe_en;                     // Port four pin0 is address strobe
    logic lclk_en;                       // Port four pin1 is logic clock
    logic csel_en;                       // Port four pin2 is chip select
    logic jtag_en;                       // Port five low nibble is JTAG
    logic stat_en;                       // Port five pin4 status output
    logic rdy_busy_sel;                  // Pin4 shows ready/busy instead
    logic perr_en;                       // Port five pin5 error output
    logic batt_en;                       // Port five pin7 battery indicator
    logic xa_mode;                       // Port six low nibble takes address
    logic data_bus_en;                   // Port six is the host data bus
  } special_cfg_type;

endpackage

// >>> hdl/port_function_mux.sv
// Pin function selection for seven general ports.
// Assumes pins arrive unsynchronised; host logic shares ref_clk.
//
// Contract
// - Ports one, two: I/O, macrocell, logic input
// - Port three pins drive external chip selects
// - Address strobe rising edge captures address port
// - Logic clock clocks macrocells, counter, array
// - Chip select low enables memories and I/O
// - Chip select falling edge ends power-down mode
// - Port five low pins carry JTAG
// - Port five pin4 shows status or ready/busy
// - Port five pin5 drives active-low error
// - Battery indicator high while on battery
// - Port six: extended address or data bus
// - Ports five to seven drive latched address
// - Direction bit zero input, one output
// - Control bit zero I/O, one address out
module port_function_mux
  import port_mux_pkg::*;
(
  // Clock, reset, enable
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  input  wire logic                  clk_en,
  // Board pins
  input  wire logic [PORT_W-1:0]     pin_i [NUM_PORTS],
  output logic [PORT_W-1:0]          pin_o [NUM_PORTS],
  output logic [PORT_W-1:0]          pin_oe [NUM_PORTS],
  // Configuration
  input  wire port_cfg_type          port_cfg [NUM_PORTS],
  input  wire pin_sel_type           pin_sel [3][PORT_W],
  input  wire pld_mode_type          pld_mode [3],
  input  wire special_cfg_type       special_cfg,
  // Internal sources
  input  wire logic [ADDR_W-1:0]     host_addr_data_port,
  input  wire logic [PORT_W-1:0]     macrocell_output [2],
  input  wire logic [PORT_W-1:0]     external_chip_selects,
  input  wire logic                  jtag_tdo,
  input  wire logic                  jtag_tdo_oe,
  input  wire logic                  program_status_out,
  input  wire logic                  ready_busy,
  input  wire logic                  program_error_n,
  input  wire logic                  on_battery,
  input  wire logic [PORT_W-1:0]     host_data_out,
  input  wire logic                  host_data_oe,
  // Internal sinks
  output logic [PORT_W-1:0]          data_in [NUM_PORTS],
  output logic [PORT_W-1:0]          pld_input [3],
  output logic [ADDR_W-1:0]          latched_addr,
  output logic                       logic_clock_in,
  output logic                       logic_clock_tick,
  output logic                       mem_io_enable,
  output logic                       powerdown_exit,
  output logic                       jtag_tms,
  output logic                       jtag_tck,
  output logic                       jtag_tdi,
  output logic [XA_ADDR_W-1:0]       ext_addr_low,
  output logic [PORT_W-1:0]          host_data_in
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [PORT_W-1:0] sync1 [NUM_PORTS];  // First stage, metastable
  logic [PORT_W-1:0] sync2 [NUM_PORTS];  // Second stage
  logic [PORT_W-1:0] sync3 [NUM_PORTS];  // Third stage
  logic [PORT_W-1:0] filt  [NUM_PORTS];  // Accepted pin level
  logic [PORT_W-1:0] agree [NUM_PORTS];  // Stages two and three match

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++)
    begin : g_sync
      // Three-stage capture, change taken once stages agree
      always_ff @(posedge ref_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          sync1[gp] <= BYTE_ZERO;
          sync2[gp] <= BYTE_ZERO;
          sync3[gp] <= BYTE_ZERO;
          filt[gp]  <= BYTE_ZERO;
        end
        else if (clk_en)
        begin
          sync1[gp] <= pin_i[gp];
          sync2[gp] <= sync1[gp];
          sync3[gp] <= sync2[gp];
          filt[gp]  <= (filt[gp] & ~agree[gp]) | (sync2[gp] & agree[gp]);
        end
      end
      assign agree[gp]   = ~(sync2[gp] ^ sync3[gp]);
      assign data_in[gp] = filt[gp];
    end
  endgenerate

  // ************************************************************
  // Edge detection on accepted levels
  // ************************************************************
  // Rising when the agreed new level is high and the old one low
  function automatic logic rises(input logic s2, input logic s3, input logic f);
    rises = s2 & s3 & ~f;
  endfunction

  // Falling when the agreed new level is low and the old one high
  function automatic logic falls(input logic s2, input logic s3, input logic f);
    falls = ~s2 & ~s3 & f;
  endfunction

  logic strobe_rise;                     // Address strobe rising
  logic lclk_rise;                       // Logic clock rising
  logic csel_fall;                       // Chip select going low

  assign strobe_rise = clk_en & special_cfg.strobe_en
                     & rises(sync2[PORT_FOUR][PIN_STROBE], sync3[PORT_FOUR][PIN_STROBE],
                             filt[PORT_FOUR][PIN_STROBE]);
  assign lclk_rise   = clk_en & special_cfg.lclk_en
                     & rises(sync2[PORT_FOUR][PIN_LCLK], sync3[PORT_FOUR][PIN_LCLK],
                             filt[PORT_FOUR][PIN_LCLK]);
  assign csel_fall   = clk_en & special_cfg.csel_en
                     & falls(sync2[PORT_FOUR][PIN_CSEL], sync3[PORT_FOUR][PIN_CSEL],
                             filt[PORT_FOUR][PIN_CSEL]);

  // ************************************************************
  // Port four functions
  // ************************************************************
  // Address capture on strobe rise
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      latched_addr <= ADDR_ZERO;
    else if (strobe_rise)
      latched_addr <= host_addr_data_port;
  end

  // Logic clock level and tick for macrocells, counter, array
  assign logic_clock_in   = special_cfg.lclk_en & filt[PORT_FOUR][PIN_LCLK];
  assign logic_clock_tick = lclk_rise;

  // Select low enables memories; unused select leaves them on
  assign mem_io_enable  = special_cfg.csel_en ? ~filt[PORT_FOUR][PIN_CSEL] : 1'b1;
  assign powerdown_exit = csel_fall;

  // ************************************************************
  // Port five and six inputs
  // ************************************************************
  // Test pins, clock already filtered like a Schmitt input
  assign jtag_tms = special_cfg.jtag_en & filt[PORT_FIVE][PIN_TMS];
  assign jtag_tck = special_cfg.jtag_en & filt[PORT_FIVE][PIN_TCK];
  assign jtag_tdi = special_cfg.jtag_en & filt[PORT_FIVE][PIN_TDI];

  // Extended address nibble and data bus input
  assign ext_addr_low = special_cfg.xa_mode ? filt[PORT_SIX][XA_ADDR_W-1:0] : '0;
  assign host_data_in = special_cfg.data_bus_en ? filt[PORT_SIX] : BYTE_ZERO;

  // ************************************************************
  // Logic array inputs, ports one to three
  // ************************************************************
  logic [PORT_W-1:0] pld_hold [3];       // Latched or registered copy

  generate
    for (gp = 0; gp < 3; gp++)
    begin : g_pld
      // Catch on strobe or on logic clock per mode
      always_ff @(posedge ref_clk or negedge nrst)
      begin
        if (!nrst)
          pld_hold[gp] <= BYTE_ZERO;
        else if ((pld_mode[gp] == PLD_LATCHED && strobe_rise)
              || (pld_mode[gp] == PLD_REGISTERED && lclk_rise))
          pld_hold[gp] <= filt[gp];
      end
      assign pld_input[gp] = (pld_mode[gp] == PLD_TRANSPARENT) ? filt[gp] : pld_hold[gp];
    end
  endgenerate

  // ************************************************************
  // Pin drive selection
  // ************************************************************
  logic [PORT_W-1:0] next_o  [NUM_PORTS]; // Drive value to register
  logic [PORT_W-1:0] next_oe [NUM_PORTS]; // Drive enable to register

  // Priority: special function, address out, alternate, plain I/O
  always_comb
  begin
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      next_o[p]  = port_cfg[p].dout & port_cfg[p].dir;
      next_oe[p] = port_cfg[p].dir;
    end
    // Ports one to three: alternate output or logic input
    for (int p = 0; p < 3; p++)
    begin
      for (int b = 0; b < PORT_W; b++)
      begin
        if (pin_sel[p][b] == SEL_ALT)
        begin
          next_o[p][b]  = (p == PORT_THREE) ? external_chip_selects[b]
                                            : macrocell_output[p][b];
          next_oe[p][b] = 1'b1;
        end
        else if (pin_sel[p][b] == SEL_PLD_IN)
        begin
          next_o[p][b]  = 1'b0;
          next_oe[p][b] = 1'b0;
        end
      end
    end
    // Ports five to seven: latched address output
    for (int p = PORT_FIVE; p <= PORT_SEVEN; p++)
    begin
      for (int b = 0; b < PORT_W; b++)
      begin
        if (port_cfg[p].ctrl[b])
        begin
          next_o[p][b]  = (p == PORT_SEVEN) ? latched_addr[HI_BYTE + b] : latched_addr[b];
          next_oe[p][b] = 1'b1;
        end
      end
    end
    // Port four special inputs never drive
    if (special_cfg.strobe_en)
      next_oe[PORT_FOUR][PIN_STROBE] = 1'b0;
    if (special_cfg.lclk_en)
      next_oe[PORT_FOUR][PIN_LCLK] = 1'b0;
    if (special_cfg.csel_en)
      next_oe[PORT_FOUR][PIN_CSEL] = 1'b0;
    // Programming interface on port five
    if (special_cfg.jtag_en)
    begin
      next_oe[PORT_FIVE][PIN_TMS] = 1'b0;
      next_oe[PORT_FIVE][PIN_TCK] = 1'b0;
      next_oe[PORT_FIVE][PIN_TDI] = 1'b0;
      next_o[PORT_FIVE][PIN_TDO]  = jtag_tdo;
      next_oe[PORT_FIVE][PIN_TDO] = jtag_tdo_oe;
    end
    if (special_cfg.stat_en)
    begin
      next_o[PORT_FIVE][PIN_STAT]  = special_cfg.rdy_busy_sel ? ready_busy : program_status_out;
      next_oe[PORT_FIVE][PIN_STAT] = 1'b1;
    end
    if (special_cfg.perr_en)
    begin
      next_o[PORT_FIVE][PIN_PERR]  = program_error_n;
      next_oe[PORT_FIVE][PIN_PERR] = 1'b1;
    end
    if (special_cfg.batt_en)
    begin
      next_o[PORT_FIVE][PIN_BATT]  = on_battery;
      next_oe[PORT_FIVE][PIN_BATT] = 1'b1;
    end
    // Port six as inputs or host data bus
    if (special_cfg.xa_mode)
      next_oe[PORT_SIX][XA_ADDR_W-1:0] = '0;
    if (special_cfg.data_bus_en)
    begin
      next_o[PORT_SIX]  = host_data_out;
      next_oe[PORT_SIX] = {PORT_W{host_data_oe}};
    end
  end

  // Registered pin drive, all inputs after reset
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        pin_o[p]  <= BYTE_ZERO;
        pin_oe[p] <= BYTE_ZERO;
      end
    end
    else if (clk_en)
    begin
      pin_o  <= next_o;
      pin_oe <= next_oe;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Registered checks also need reset gone at the trigger edge,
  // since the release edge itself still loads reset values
  property p_dir_out;
    nrst && clk_en && port_cfg[PORT_SEVEN].dir[0] && !port_cfg[PORT_SEVEN].ctrl[0]
      |=> pin_oe[PORT_SEVEN][0] && pin_o[PORT_SEVEN][0] == $past(port_cfg[PORT_SEVEN].dout[0]);
  endproperty
  a_dir_out: assert property (p_dir_out) else $error("direction one did not drive data");

  property p_addr_out;
    nrst && clk_en && port_cfg[PORT_SEVEN].ctrl[0]
      |=> pin_oe[PORT_SEVEN][0] && pin_o[PORT_SEVEN][0] == $past(latched_addr[HI_BYTE]);
  endproperty
  a_addr_out: assert property (p_addr_out) else $error("address out not driven");

  property p_strobe;
    strobe_rise |=> latched_addr == $past(host_addr_data_port);
  endproperty
  a_strobe: assert property (p_strobe) else $error("address not captured on strobe");

  property p_csel;
    nrst && clk_en && special_cfg.csel_en
      && sync2[PORT_FOUR][PIN_CSEL] == sync3[PORT_FOUR][PIN_CSEL]
      |=> !special_cfg.csel_en || mem_io_enable == !$past(sync3[PORT_FOUR][PIN_CSEL]);
  endproperty
  a_csel: assert property (p_csel) else $error("select level wrong");

  property p_wake;
    clk_en && powerdown_exit |=> !filt[PORT_FOUR][PIN_CSEL] && $past(filt[PORT_FOUR][PIN_CSEL]);
  endproperty
  a_wake: assert property (p_wake) else $error("wake without select edge");

  property p_tick;
    clk_en && logic_clock_tick |=> logic_clock_in && !$past(logic_clock_in);
  endproperty
  a_tick: assert property (p_tick) else $error("tick without clock rise");

  property p_ecs;
    nrst && clk_en && pin_sel[PORT_THREE][0] == SEL_ALT
      |=> pin_oe[PORT_THREE][0] && pin_o[PORT_THREE][0] == $past(external_chip_selects[0]);
  endproperty
  a_ecs: assert property (p_ecs) else $error("chip select not driven");

  property p_batt;
    nrst && clk_en && special_cfg.batt_en
      |=> pin_oe[PORT_FIVE][PIN_BATT] && pin_o[PORT_FIVE][PIN_BATT] == $past(on_battery);
  endproperty
  a_batt: assert property (p_batt) else $error("battery indicator wrong");

  property p_jtag_in;
    nrst && clk_en && special_cfg.jtag_en |=> !pin_oe[PORT_FIVE][PIN_TMS] && !pin_oe[PORT_FIVE][PIN_TCK];
  endproperty
  a_jtag_in: assert property (p_jtag_in) else $error("test input driven");

endmodule

// >>> dv/pin_board_model.sv
// Board model that stands behind the seven general ports.
// Assumes the bench sets the level of every pin the device leaves undriven.
module pin_board_model
  import port_mux_pkg::*;
(
  // Device side
  input  wire logic [PORT_W-1:0] pin_o   [NUM_PORTS],
  input  wire logic [PORT_W-1:0] pin_oe  [NUM_PORTS],
  // Board side
  input  wire logic [PORT_W-1:0] ext_lvl [NUM_PORTS],
  output logic      [PORT_W-1:0] pin_i   [NUM_PORTS]
);
  timeunit 1ns;
  timeprecision 100ps;

  // ************************************************************
  // Wire level
  // ************************************************************
  // Driven bits come from the device, released bits from the board
  always_comb
  begin
    for (int p = 0; p < NUM_PORTS; p++)
      pin_i[p] = (pin_o[p] & pin_oe[p]) | (ext_lvl[p] & ~pin_oe[p]);
  end
endmodule

// >>> dv/port_function_mux_tb.sv
// Self-checking bench for the port function multiplexer.
// Assumes the pin board model and the shared package.
module port_function_mux_tb
  import port_mux_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ************************************************************
  // Signals
  // ************************************************************
  logic            ref_clk = 1'b0;        // 125 MHz clock
  logic            nrst = 1'b0;           // Reset, active low
  logic            clk_en = 1'b1;         // State advance enable
  logic [7:0]      pin_i [NUM_PORTS];     // Wire levels
  logic [7:0]      pin_o [NUM_PORTS];     // Device drive values
  logic [7:0]      pin_oe [NUM_PORTS];    // Device drive enables
  logic [7:0]      ext_lvl [NUM_PORTS];   // Board levels
  port_cfg_type    port_cfg [NUM_PORTS];  // Port registers
  pin_sel_type     pin_sel [3][PORT_W];   // Pin functions
  pld_mode_type    pld_mode [3];          // Array input modes
  special_cfg_type sc;                    // Special enables
  logic [15:0]     host_addr;             // Address port
  logic [7:0]      mc_out [2];            // Macrocell outputs
  logic [7:0]      ecs;                   // Chip selects
  logic            tdo, tdo_oe, stat, rdy, perr_n, on_batt;
  logic [7:0]      hd_out;                // Host data out
  logic            hd_oe;                 // Host data enable
  logic [7:0]      data_in [NUM_PORTS];   // Filtered pin levels
  logic [7:0]      pld_in [3];            // Array inputs
  logic [15:0]     latched_addr;          // Captured address
  logic            lclk, tick, mem_en, pd_exit, tms, tck, tdi;
  logic [3:0]      xa_low;                // Extended address
  logic [7:0]      hd_in;                 // Host data in
  logic [15:0]     ticks, pd_count;       // Pulse counters
  int              bad_count = 0;         // Mismatches
  int              n_checks = 0;          // Comparisons
  int              cycles = 0;            // Timeout counter
  // One table row: config, board level, expected results
  typedef struct {
    int p; logic [7:0] dir, dout, ext; pin_sel_type sel; logic [7:0] eoe, eo, edin;
  } row_type;
  row_type rows [11] = '{
    '{0, 8'hFF, 8'h5A, 8'h00, SEL_MCU_IO, 8'hFF, 8'h5A, 8'h5A},
    '{0, 8'h00, 8'hFF, 8'hC3, SEL_MCU_IO, 8'h00, 8'h00, 8'hC3},
    '{1, 8'hF0, 8'hA5, 8'h3C, SEL_MCU_IO, 8'hF0, 8'hA0, 8'hAC},
    '{0, 8'hFF, 8'h00, 8'h00, SEL_ALT, 8'hFF, 8'h96, 8'h96},
    '{1, 8'hFF, 8'h00, 8'h00, SEL_ALT, 8'hFF, 8'h69, 8'h69},
    '{2, 8'hFF, 8'h00, 8'h00, SEL_ALT, 8'hFF, 8'hE1, 8'hE1},
    '{2, 8'hFF, 8'h00, 8'h77, SEL_PLD_IN, 8'h00, 8'h00, 8'h77},
    '{3, 8'hFF, 8'h42, 8'h00, SEL_MCU_IO, 8'hFF, 8'h42, 8'h42},
    '{4, 8'hFF, 8'h81, 8'h00, SEL_MCU_IO, 8'hFF, 8'h81, 8'h81},
    '{5, 8'h0F, 8'hFF, 8'hF0, SEL_MCU_IO, 8'h0F, 8'h0F, 8'hFF},
    '{6, 8'hFF, 8'h3C, 8'h00, SEL_MCU_IO, 8'hFF, 8'h3C, 8'h3C}};

  port_function_mux dut_u (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe(pin_oe), .port_cfg(port_cfg), .pin_sel(pin_sel), .pld_mode(pld_mode),
    .special_cfg(sc), .host_addr_data_port(host_addr), .macrocell_output(mc_out),
    .external_chip_selects(ecs), .jtag_tdo(tdo), .jtag_tdo_oe(tdo_oe), .program_status_out(stat),
    .ready_busy(rdy), .program_error_n(perr_n), .on_battery(on_batt), .host_data_out(hd_out),
    .host_data_oe(hd_oe), .data_in(data_in), .pld_input(pld_in), .latched_addr(latched_addr),
    .logic_clock_in(lclk), .logic_clock_tick(tick), .mem_io_enable(mem_en),
    .powerdown_exit(pd_exit), .jtag_tms(tms), .jtag_tck(tck), .jtag_tdi(tdi),
    .ext_addr_low(xa_low), .host_data_in(hd_in));
  pin_board_model brd_u (.pin_o(pin_o), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_i(pin_i));

  // Clock, pulse counters off the sampling edge, hang guard
  always #4 ref_clk = ~ref_clk;
  always @(negedge ref_clk)
  begin
    if (tick === 1'b1) ticks <= ticks + 16'h1;
    if (pd_exit === 1'b1) pd_count <= pd_count + 16'h1;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  // ************************************************************
  // Tasks and tests
  // ************************************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Apply a row, or return its port to plain input
  task automatic put_row(input row_type x, input logic on);
    port_cfg[x.p] <= '{on ? x.dir : 8'h00, on ? x.dout : 8'h00, 8'h00};
    ext_lvl[x.p] <= on ? x.ext : 8'h00;
    if (x.p < 3)
    begin
      for (int b = 0; b < PORT_W; b++)
        pin_sel[x.p][b] <= on ? x.sel : SEL_MCU_IO;
    end
  endtask
  task automatic wrap_up();
    $display("checks=%0d bad=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      port_cfg[p] = '0;
      ext_lvl[p] = 8'h00;
    end
    for (int i = 0; i < 3; i++)
    begin
      pld_mode[i] = PLD_TRANSPARENT;
      for (int b = 0; b < PORT_W; b++) pin_sel[i][b] = SEL_MCU_IO;
    end
    sc = '0;
    host_addr = 16'h0000;
    mc_out[0] = 8'h96;
    mc_out[1] = 8'h69;
    ecs = 8'hE1;
    {tdo, tdo_oe, stat, rdy, perr_n, on_batt, hd_oe} = '0;
    hd_out = 8'h00;
    ticks = 16'h0;
    pd_count = 16'h0;
    // Reset held 20 cycles; all pins inputs before and after
    cyc(20);
    for (int p = 0; p < NUM_PORTS; p++) check(pin_oe[p], 8'h00);
    nrst <= 1'b1;
    cyc(3);
    for (int p = 0; p < NUM_PORTS; p++) check(pin_oe[p] | data_in[p], 8'h00);
    check(latched_addr, 16'h0000);
    // Table of plain, alternate and array-input cases
    foreach (rows[i])
    begin
      put_row(rows[i], 1'b1);
      cyc(6);
      check(pin_oe[rows[i].p], rows[i].eoe);
      check(pin_o[rows[i].p] & pin_oe[rows[i].p], rows[i].eo);
      check(data_in[rows[i].p], rows[i].edin);
      if (rows[i].p < 3) check(pld_in[rows[i].p], rows[i].edin);
      put_row(rows[i], 1'b0);
      cyc(1);
    end
    // Strobe rise catches address and latched array inputs once
    sc.strobe_en <= 1'b1;
    pld_mode[0] <= PLD_LATCHED;
    for (int b = 0; b < PORT_W; b++) pin_sel[0][b] <= SEL_PLD_IN;
    ext_lvl[0] <= 8'h5A;
    host_addr <= 16'hB4C7;
    cyc(6);
    ext_lvl[3][PIN_STROBE] <= 1'b1;
    cyc(6);
    ext_lvl[0] <= 8'hFF;
    host_addr <= 16'h1234;
    cyc(6);
    check(latched_addr, 16'hB4C7);
    check(pld_in[0], 8'h5A);
    // Address bytes out, mixed per bit on port seven
    port_cfg[4] <= '{8'hFF, 8'h00, 8'hFF};
    port_cfg[5] <= '{8'hFF, 8'h00, 8'hFF};
    port_cfg[6] <= '{8'hFF, 8'hF0, 8'h0F};
    cyc(2);
    check(pin_o[4], 8'hC7);
    check(pin_o[5] & pin_oe[5], 8'hC7);
    check(pin_o[6] & pin_oe[6], 8'hF4);
    // Logic clock ticks registered inputs on rise only
    port_cfg[4] <= '0;
    port_cfg[5] <= '0;
    port_cfg[6] <= '0;
    port_cfg[3] <= '{8'hFF, 8'hFF, 8'h00};
    sc.lclk_en <= 1'b1;
    pld_mode[1] <= PLD_REGISTERED;
    for (int b = 0; b < PORT_W; b++) pin_sel[1][b] <= SEL_PLD_IN;
    ext_lvl[1] <= 8'hA5;
    cyc(6);
    ticks = 16'h0;
    ext_lvl[3][PIN_LCLK] <= 1'b1;
    cyc(6);
    check(ticks, 16'h1);
    check(lclk, 1'b1);
    check(pld_in[1], 8'hA5);
    check(pin_oe[3], 8'hFC);
    ext_lvl[1] <= 8'h5A;
    ext_lvl[3][PIN_LCLK] <= 1'b0;
    cyc(6);
    check(pld_in[1], 8'hA5);
    check(ticks, 16'h1);
    // Select low enables memories; its falling edge ends power-down
    sc.lclk_en <= 1'b0;
    sc.csel_en <= 1'b1;
    ext_lvl[3][PIN_CSEL] <= 1'b1;
    cyc(6);
    check(mem_en, 1'b0);
    check(lclk, 1'b0);
    pd_count = 16'h0;
    ext_lvl[3][PIN_CSEL] <= 1'b0;
    cyc(6);
    check(mem_en, 1'b1);
    ext_lvl[3][PIN_CSEL] <= 1'b1;
    cyc(6);
    check(mem_en, 1'b0);
    check(pd_count, 16'h1);
    // Programming and battery pins, both levels of each
    sc <= '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    ext_lvl[4] <= 8'h05;
    {tdo, tdo_oe, stat, perr_n, on_batt} <= 5'b11101;
    cyc(6);
    check({tms, tck, tdi}, 3'b101);
    check(pin_oe[4], 8'hB8);
    check(pin_o[4] & 8'hB8, 8'h98);
    sc.rdy_busy_sel <= 1'b1;
    ext_lvl[4] <= 8'h02;
    {tdo, rdy, perr_n, on_batt} <= 4'b0010;
    cyc(6);
    check({tms, tck, tdi}, 3'b010);
    check(pin_o[4] & 8'hB8, 8'h20);
    // Port six as extended address and data bus
    sc <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    ext_lvl[5] <= 8'h9E;
    cyc(6);
    check(xa_low, 4'hE);
    check(hd_in, 8'h9E);
    hd_out <= 8'h3B;
    hd_oe <= 1'b1;
    cyc(2);
    check(pin_o[5] & pin_oe[5], 8'h3B);
    // Clock enable low freezes the drive registers
    clk_en <= 1'b0;
    port_cfg[6] <= '{8'hFF, 8'hAA, 8'h00};
    cyc(3);
    check(pin_oe[6], 8'h00);
    clk_en <= 1'b1;
    cyc(2);
    check(pin_o[6], 8'hAA);
    // Reset in mid-run drops every drive and the address latch
    nrst <= 1'b0;
    cyc(2);
    check(pin_oe[6] | pin_oe[5] | pin_oe[3], 8'h00);
    check(latched_addr, 16'h0000);
    nrst <= 1'b1;
    cyc(3);
    wrap_up();
  end
endmodule
